// File: verilog/rtcc_ctrl.sv
// Calendar counter control: access enable, run and format control, periodic
// and alarm flags, hold handshake and the shared counter interrupt.
// Assumes a single-cycle register port on the system clock and an alarm
// comparator outside that pulses alarm_hit_i on a match.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps

// Function
// - Access enable low holds the whole counter in reset.
// - Access enable low: control writes ignored, reads give reset values.
// - Access enable gates register access and the counter reset, never the sub clock synchroniser.
// - Run bit stops counting at 0, starts counting at 1.
// - Hour format bit: 0 twelve-hour with pm flag, 1 twenty-four-hour.
// - Interval select picks none, half second, second, minute, hour, day, month.
// - Alarm match enable makes alarm comparison valid only when 1.
// - Alarm interrupt enable lets an alarm match raise the interrupt.
// - Alarm flag set one sub clock after a match, only when enabled.
// - Both flags cleared by writing 0; writing 1 has no effect.
// - Periodic flag set on every selected interval event.
// - Hold status reads 0 when counting, 1 once hold has taken effect.
// - Hold request at 0 keeps the counters counting normally.
// - Reset clears peripheral enable and both control registers to zero.
// - Hold request stops the counters and takes effect within one sub clock.
// - Prescaler overflow during hold counts up after hold is released.
// - Periodic and alarm events share one interrupt, told apart by flags.
module rtcc_ctrl
  import rtcc_pkg::*;
#(
  parameter int HOLD_MAX_CYC = HOLD_WAIT_CYC,
  parameter int DAYS         = DAY_MAX
)
(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rd_data_o,
  // Sub clock pin and alarm comparator
  input  wire logic              sub_clk_i,
  input  wire logic              alarm_hit_i,
  // Shared counter interrupt
  output logic                   clock_event_irq_o
);

  typedef struct packed {
    logic [7:0] pce;
    logic       run;
    logic       fmt24;
    logic [2:0] ivs;
    logic       ale;
    logic       aie;
    logic       afg;
    logic       pfg;
    logic       hst;
    logic       hrq;
    logic       alm_pend;
    logic       irq;
    logic [7:0] rdata;
  } rtcc_ctrl_type;

  rtcc_ctrl_type r;
  rtcc_ctrl_type n;

  logic       sub_tick;
  logic       ev_half;
  logic       ev_sec;
  logic       ev_min;
  logic       ev_hour;
  logic       ev_day;
  logic       ev_mon;
  logic [4:0] hour;
  logic       acc_en;
  logic       per_evt;
  logic       alm_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic ivs_event(input logic [2:0] sel, input logic [5:0] ev);
    unique case (sel)
      IVS_NONE: ivs_event = 1'b0;
      IVS_HALF: ivs_event = ev[0] | ev[1];
      IVS_SEC:  ivs_event = ev[1];
      IVS_MIN:  ivs_event = ev[2];
      IVS_HOUR: ivs_event = ev[3];
      IVS_DAY:  ivs_event = ev[4];
      default:  ivs_event = ev[5];
    endcase
  endfunction

  function automatic logic [7:0] hour_view(input logic [4:0] h, input logic f24);
    logic [7:0] v;
    v = {3'h0, h};
    if (!f24)
    begin
      if (h == 5'h00)
        v = {3'h0, HOUR_NOON};
      else if (h > HOUR_NOON)
        v = {3'h1, h - HOUR_NOON};
      else if (h == HOUR_NOON)
        v = {3'h1, HOUR_NOON};
    end
    hour_view = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sub clock and time base

  rtcc_sub_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .sub_clk_i (sub_clk_i),
    .tick_o    (sub_tick)
  );

  assign acc_en = r.pce[PCE_EN_BIT];

  // Counter in reset while access is off
  rtcc_time_base #(
    .DAYS (DAYS)
  ) u_tb (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .clr_i     (~acc_en),
    .tick_i    (sub_tick),
    .run_i     (r.run),
    .hold_i    (r.hst),
    .ev_half_o (ev_half),
    .ev_sec_o  (ev_sec),
    .ev_min_o  (ev_min),
    .ev_hour_o (ev_hour),
    .ev_day_o  (ev_day),
    .ev_mon_o  (ev_mon),
    .hour_o    (hour)
  );

  assign per_evt = acc_en & ivs_event(r.ivs, {ev_mon, ev_day, ev_hour, ev_min, ev_sec, ev_half});
  assign alm_evt = acc_en & r.ale & r.alm_pend & sub_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Register and flag logic

  always_comb
  begin
    n       = r;
    n.irq   = 1'b0;
    n.rdata = 8'h00;
    if (wr_i && addr_i == PCE_ADDR)
      n.pce = wr_data_i & PCE_MASK;
    if (!acc_en)
    begin
      n.run      = CC0_RST[CC0_RUN_BIT];
      n.fmt24    = CC0_RST[CC0_FMT_BIT];
      n.ivs      = CC0_RST[CC0_IVS_LSB +: 3];
      n.ale      = CC1_RST[CC1_ALE_BIT];
      n.aie      = CC1_RST[CC1_AIE_BIT];
      n.afg      = CC1_RST[CC1_AFG_BIT];
      n.pfg      = CC1_RST[CC1_PFG_BIT];
      n.hst      = CC1_RST[CC1_HST_BIT];
      n.hrq      = CC1_RST[CC1_HRQ_BIT];
      n.alm_pend = 1'b0;
    end
    else
    begin
      if (wr_i && addr_i == CC0_ADDR)
      begin
        n.run   = wr_data_i[CC0_RUN_BIT];
        n.fmt24 = wr_data_i[CC0_FMT_BIT];
        n.ivs   = wr_data_i[CC0_IVS_LSB +: 3];
      end
      if (wr_i && addr_i == CC1_ADDR)
      begin
        n.ale = wr_data_i[CC1_ALE_BIT];
        n.aie = wr_data_i[CC1_AIE_BIT];
        n.hrq = wr_data_i[CC1_HRQ_BIT];
        // Write 0 clears, write 1 ignored
        if (!wr_data_i[CC1_AFG_BIT])
          n.afg = 1'b0;
        if (!wr_data_i[CC1_PFG_BIT])
          n.pfg = 1'b0;
      end
      if (alarm_hit_i && r.ale)
        n.alm_pend = 1'b1;
      else if (!r.ale || sub_tick)
        n.alm_pend = 1'b0;
      // Flag one sub clock after match; set wins
      if (alm_evt)
        n.afg = 1'b1;
      if (per_evt)
        n.pfg = 1'b1;
      n.irq = per_evt | (alm_evt & r.aie);
      // Hold takes effect on next sub tick
      if (!r.hrq)
        n.hst = 1'b0;
      else if (sub_tick)
        n.hst = 1'b1;
    end
    if (rd_i)
    begin
      unique case (addr_i)
        PCE_ADDR:   n.rdata = r.pce;
        CC0_ADDR:   n.rdata = acc_en ? {r.run, 3'h0, r.fmt24, r.ivs} : CC0_RST;
        CC1_ADDR:   n.rdata = acc_en ? {1'b0, r.ale, r.aie, 1'b0, r.afg, r.pfg, r.hst, r.hrq}
                                     : CC1_RST;
        HVIEW_ADDR: n.rdata = acc_en ? hour_view(hour, r.fmt24) : 8'h00;
        default:    n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      r <= '0;
    else
      r <= n;
  end

  assign rd_data_o         = r.rdata;
  assign clock_event_irq_o = r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  int unsigned hold_wait;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      hold_wait <= 0;
    else if (r.hrq && !r.hst)
      hold_wait <= hold_wait + 1;
    else
      hold_wait <= 0;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  a_off_ctrl_reset: assert property (
    !acc_en |=> !r.run && !r.ale && !r.hrq && !r.pfg && !r.afg)
    else $error("control not at reset while access off");
  a_off_read_dflt: assert property (
    rd_i && !acc_en && addr_i == CC1_ADDR |=> rd_data_o == CC1_RST)
    else $error("read while access off not default");
  a_stop_no_count: assert property (
    !r.run && !$past(r.run) |-> !ev_sec && !ev_half)
    else $error("count-up while stopped");
  a_pm_view: assert property (
    rd_i && acc_en && addr_i == HVIEW_ADDR && !r.fmt24 && hour >= HOUR_NOON
    |=> rd_data_o[HV_PM_BIT])
    else $error("pm indication missing");
  a_alarm_flag_time: assert property (
    $rose(r.afg) |-> $past(sub_tick) && $past(r.ale) && $past(r.alm_pend))
    else $error("alarm flag set without match and sub tick");
  a_flag_clear: assert property (
    wr_i && acc_en && addr_i == CC1_ADDR && !wr_data_i[CC1_PFG_BIT] && !per_evt
    |=> !r.pfg)
    else $error("periodic flag not cleared by zero write");
  a_alarm_clear: assert property (
    wr_i && acc_en && addr_i == CC1_ADDR && !wr_data_i[CC1_AFG_BIT] && !alm_evt
    |=> !r.afg)
    else $error("alarm flag not cleared by zero write");
  a_alarm_irq_gate: assert property (
    alm_evt && !per_evt |=> clock_event_irq_o == $past(r.aie))
    else $error("alarm interrupt not gated by its enable");
  a_periodic_set: assert property (
    per_evt |=> r.pfg && clock_event_irq_o)
    else $error("periodic event lost");
  a_hold_release: assert property (
    !r.hrq |=> !r.hst)
    else $error("hold status without request");
  a_hold_stops: assert property (
    r.hst |-> !ev_sec)
    else $error("count-up during hold");
  a_hold_latency: assert property (
    hold_wait <= HOLD_MAX_CYC + 1)
    else $error("hold took longer than one sub clock");
  a_irq_cause: assert property (
    clock_event_irq_o |-> $past(per_evt) || ($past(alm_evt) && $past(r.aie)))
    else $error("interrupt without cause");

  c_periodic_irq: cover property (per_evt ##1 clock_event_irq_o);
  c_alarm_flag:   cover property ($rose(r.afg) && r.aie);
  c_hold_entry:   cover property ($rose(r.hst));
  c_flag_clear:   cover property ($fell(r.pfg));

endmodule // rtcc_ctrl

// File: verilog/rtcc_pkg.sv
// Shared constants of the calendar counter control block.
// Assumes one 200 MHz system clock and an 8-bit peripheral register port.
package rtcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses on the peripheral port)
  localparam int          ADDR_W     = 20;
  localparam logic [19:0] PCE_ADDR   = 20'hf_00f0;
  localparam logic [19:0] CC0_ADDR   = 20'hf_ff9d;
  localparam logic [19:0] CC1_ADDR   = 20'hf_ff9e;
  localparam logic [19:0] HVIEW_ADDR = 20'hf_ff80;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and masks
  localparam logic [7:0] PCE_RST  = 8'h00;
  localparam logic [7:0] CC0_RST  = 8'h00;
  localparam logic [7:0] CC1_RST  = 8'h00;
  localparam logic [7:0] PCE_MASK = 8'hb4;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int PCE_EN_BIT  = 7;
  localparam int CC0_RUN_BIT = 7;
  localparam int CC0_FMT_BIT = 3;
  localparam int CC0_IVS_LSB = 0;
  localparam int CC1_ALE_BIT = 6;
  localparam int CC1_AIE_BIT = 5;
  localparam int CC1_AFG_BIT = 3;
  localparam int CC1_PFG_BIT = 2;
  localparam int CC1_HST_BIT = 1;
  localparam int CC1_HRQ_BIT = 0;
  localparam int HV_PM_BIT   = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Interval select codes
  localparam logic [2:0] IVS_NONE = 3'h0;
  localparam logic [2:0] IVS_HALF = 3'h1;
  localparam logic [2:0] IVS_SEC  = 3'h2;
  localparam logic [2:0] IVS_MIN  = 3'h3;
  localparam logic [2:0] IVS_HOUR = 3'h4;
  localparam logic [2:0] IVS_DAY  = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Counting constants
  localparam logic [14:0] PRESC_MAX  = 15'h7fff;
  localparam logic [14:0] PRESC_HALF = 15'h3fff;
  localparam logic [5:0]  SEC_MAX    = 6'h3b;
  localparam logic [5:0]  MIN_MAX    = 6'h3b;
  localparam logic [4:0]  HOUR_MAX   = 5'h17;
  localparam logic [4:0]  HOUR_NOON  = 5'h0c;
  localparam logic [4:0]  DAY_FIRST  = 5'h01;
  localparam int          DAY_MAX    = 31;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int SYS_CLK_HZ    = 200_000_000;
  localparam int SUB_CLK_HZ    = 32_768;
  localparam int HOLD_WAIT_CYC = SYS_CLK_HZ / SUB_CLK_HZ;

endpackage

// File: verilog/rtcc_sub_sync.sv
// Sub clock pin synchroniser and rising-edge tick generator.
// Assumes the sub clock is far slower than the system clock.
`timescale 1ns/1ps

module rtcc_sub_sync
  import rtcc_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // Sub clock pin
  input  wire logic sub_clk_i,
  // One-cycle tick per sub clock period
  output logic      tick_o
);

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic lvl;
    logic tick;
  } rtcc_sync_type;

  rtcc_sync_type r;
  rtcc_sync_type n;

  always_comb
  begin
    n      = r;
    n.ff1  = sub_clk_i;
    n.ff2  = r.ff1;
    n.ff3  = r.ff2;
    n.tick = 1'b0;
    // Level accepted once second and third stage agree
    if (r.ff2 == r.ff3)
    begin
      n.lvl  = r.ff3;
      n.tick = r.ff3 & ~r.lvl;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      r <= '0;
    else
      r <= n;
  end

  assign tick_o = r.tick;

endmodule // rtcc_sub_sync

// File: verilog/rtcc_time_base.sv
// Sub-second prescaler and seconds-to-day time base producing count-up events.
// Assumes tick_i is a one-cycle pulse per sub clock period.
`timescale 1ns/1ps

module rtcc_time_base
  import rtcc_pkg::*;
#(
  parameter int DAYS = DAY_MAX
)
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // Control
  input  wire logic       clr_i,
  input  wire logic       tick_i,
  input  wire logic       run_i,
  input  wire logic       hold_i,
  // Count-up events
  output logic            ev_half_o,
  output logic            ev_sec_o,
  output logic            ev_min_o,
  output logic            ev_hour_o,
  output logic            ev_day_o,
  output logic            ev_mon_o,
  // Hour count, binary 0..23
  output logic [4:0]      hour_o
);

  typedef struct packed {
    logic [14:0] presc;
    logic        pend;
    logic [5:0]  sec;
    logic [5:0]  min;
    logic [4:0]  hour;
    logic [4:0]  day;
    logic [5:0]  evs;
  } rtcc_tb_type;

  localparam rtcc_tb_type TB_RST = '{presc: '0, pend: 1'b0, sec: '0, min: '0,
                                     hour: '0, day: DAY_FIRST, evs: '0};
  localparam logic [4:0]  DAY_LAST = 5'(DAYS);

  rtcc_tb_type r;
  rtcc_tb_type n;

  always_comb
  begin
    n     = r;
    n.evs = '0;
    if (clr_i)
      n = TB_RST;
    else if (run_i)
    begin
      // Prescaler keeps running during hold
      if (tick_i)
      begin
        n.evs[0] = (r.presc == PRESC_HALF);
        n.presc  = (r.presc == PRESC_MAX) ? '0 : r.presc + 15'h0001;
        n.pend   = r.pend | (r.presc == PRESC_MAX);
      end
      if (r.pend && !hold_i)
      begin
        n.pend   = 1'b0;
        n.evs[1] = 1'b1;
        n.sec    = (r.sec == SEC_MAX) ? '0 : r.sec + 6'h01;
        if (r.sec == SEC_MAX)
        begin
          n.evs[2] = 1'b1;
          n.min    = (r.min == MIN_MAX) ? '0 : r.min + 6'h01;
          if (r.min == MIN_MAX)
          begin
            n.evs[3] = 1'b1;
            n.hour   = (r.hour == HOUR_MAX) ? '0 : r.hour + 5'h01;
            if (r.hour == HOUR_MAX)
            begin
              n.evs[4] = 1'b1;
              n.evs[5] = (r.day == DAY_LAST);
              n.day    = (r.day == DAY_LAST) ? DAY_FIRST : r.day + 5'h01;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      r <= TB_RST;
    else
      r <= n;
  end

  assign ev_half_o = r.evs[0];
  assign ev_sec_o  = r.evs[1];
  assign ev_min_o  = r.evs[2];
  assign ev_hour_o = r.evs[3];
  assign ev_day_o  = r.evs[4];
  assign ev_mon_o  = r.evs[5];
  assign hour_o    = r.hour;

endmodule // rtcc_time_base

// File: bench/tb_calendar_counter_control.sv
// Self-checking bench for the calendar counter control block.
// Assumes rtcc_ctrl behind a one-cycle register port and a fast sub clock.
`timescale 1ns/1ps

module tb_calendar_counter_control
  import rtcc_pkg::*;
;
  logic              sys_clk_i;
  logic              nrst_i;
  logic [ADDR_W-1:0] addr_i;
  logic [7:0]        wr_data_i;
  logic              wr_i;
  logic              rd_i;
  logic [7:0]        rd_data_o;
  logic              sub_clk_i;
  logic              alarm_hit_i;
  logic              clock_event_irq_o;
  int                fails;
  int                num_checks;
  int                irq_cnt;
  logic [7:0]        rdv;
  logic [7:0]        d;
  logic [19:0]       a;

  ////////////////////////////////////////////////////////////////////////////
  // Design, clocks and interrupt counter
  rtcc_ctrl #(.HOLD_MAX_CYC(40), .DAYS(DAY_MAX)) dut
  (
    .sys_clk_i         (sys_clk_i),
    .nrst_i            (nrst_i),
    .addr_i            (addr_i),
    .wr_data_i         (wr_data_i),
    .wr_i              (wr_i),
    .rd_i              (rd_i),
    .rd_data_o         (rd_data_o),
    .sub_clk_i         (sub_clk_i),
    .alarm_hit_i       (alarm_hit_i),
    .clock_event_irq_o (clock_event_irq_o)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // Sub clock free-running at 40 system cycles, phase unrelated
  initial
  begin
    sub_clk_i = 1'b0;
    #3.3;
    forever #100 sub_clk_i = ~sub_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    if (clock_event_irq_o === 1'b1)
      irq_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic reg_wr(input logic [19:0] ad, input logic [7:0] dt);
    @(posedge sys_clk_i);
    addr_i    <= ad;
    wr_data_i <= dt;
    wr_i      <= 1'b1;
    @(posedge sys_clk_i);
    wr_i      <= 1'b0;
  endtask

  task automatic reg_rd(input logic [19:0] ad, output logic [7:0] dt);
    @(posedge sys_clk_i);
    addr_i <= ad;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    #1;
    dt = rd_data_o;
  endtask

  task automatic rd_chk(input logic [19:0] ad, input logic [7:0] exp);
    reg_rd(ad, rdv);
    check(rdv, exp);
  endtask

  // One alarm match pulse, then room for the next sub tick
  task automatic hit();
    @(posedge sys_clk_i);
    alarm_hit_i <= 1'b1;
    @(posedge sys_clk_i);
    alarm_hit_i <= 1'b0;
    repeat (100) @(posedge sys_clk_i);
  endtask

  function automatic logic [7:0] cc0_exp(input logic [7:0] v);
    return v & 8'h8f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #100_000;
    fails++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    nrst_i      = 1'b0;
    addr_i      = '0;
    wr_data_i   = 8'h00;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    alarm_hit_i = 1'b0;
    fails       = 0;
    num_checks  = 0;
    irq_cnt     = 0;
    void'($urandom(43));
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    rd_chk(PCE_ADDR, PCE_RST);
    rd_chk(CC0_ADDR, CC0_RST);
    rd_chk(CC1_ADDR, CC1_RST);
    // Access disabled: writes dropped, reads give defaults
    reg_wr(CC0_ADDR, 8'h8a);
    reg_wr(CC1_ADDR, 8'h61);
    rd_chk(CC0_ADDR, CC0_RST);
    rd_chk(CC1_ADDR, CC1_RST);
    reg_wr(PCE_ADDR, 8'hff);
    rd_chk(PCE_ADDR, PCE_MASK);
    reg_wr(PCE_ADDR, 8'h80);
    rd_chk(PCE_ADDR, 8'h80);
    // Random control 0 values and unmapped addresses
    for (int i = 0; i < 24; i++)
    begin
      d = 8'($urandom);
      reg_wr(CC0_ADDR, d);
      rd_chk(CC0_ADDR, cc0_exp(d));
      a = 20'($urandom) & 20'h0_ff7f;
      reg_wr(a, 8'hff);
      rd_chk(a, 8'h00);
    end
    reg_wr(CC1_ADDR, 8'h00);
    reg_wr(CC0_ADDR, 8'h00);
    rd_chk(HVIEW_ADDR, 8'h0c);
    reg_wr(CC1_ADDR, 8'h01);
    reg_wr(CC0_ADDR, 8'h08);
    rd_chk(CC0_ADDR, 8'h08);
    rd_chk(HVIEW_ADDR, 8'h00);
    reg_wr(CC1_ADDR, 8'h00);
    // Alarm set up with matching off
    reg_wr(CC1_ADDR, 8'h20);
    // Alarm with match and interrupt enabled
    reg_wr(CC1_ADDR, 8'h60);
    hit();
    check(8'(irq_cnt), 8'h01);
    rd_chk(CC1_ADDR, 8'h68);
    reg_wr(CC1_ADDR, 8'h68);
    rd_chk(CC1_ADDR, 8'h68);
    reg_wr(CC1_ADDR, 8'h60);
    rd_chk(CC1_ADDR, 8'h60);
    // Match disabled: no flag, no interrupt
    // Enable changed, flags cleared
    reg_wr(CC1_ADDR, 8'h20);
    hit();
    rd_chk(CC1_ADDR, 8'h20);
    check(8'(irq_cnt), 8'h01);
    // Match on, interrupt off: flag only
    reg_wr(CC1_ADDR, 8'h40);
    hit();
    rd_chk(CC1_ADDR, 8'h48);
    check(8'(irq_cnt), 8'h01);
    reg_wr(CC1_ADDR, 8'h00);
    rd_chk(CC1_ADDR, 8'h00);
    // Hold handshake within 40 status reads (two sub clocks)
    reg_wr(CC1_ADDR, 8'h01);
    for (int i = 0; i < 40; i++)
    begin
      reg_rd(CC1_ADDR, rdv);
      if (rdv[CC1_HST_BIT] === 1'b1)
        break;
    end
    check(rdv, 8'h03);
    reg_wr(CC1_ADDR, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    rd_chk(CC1_ADDR, 8'h00);
    // Flag set, then access disabled resets the counter side
    reg_wr(CC1_ADDR, 8'h40);
    hit();
    reg_wr(PCE_ADDR, 8'h00);
    rd_chk(CC1_ADDR, CC1_RST);
    rd_chk(CC0_ADDR, CC0_RST);
    reg_wr(PCE_ADDR, 8'h80);
    rd_chk(CC1_ADDR, 8'h00);
    rd_chk(CC0_ADDR, CC0_RST);
    end_of_test();
  end

endmodule // tb_calendar_counter_control
